// File: design/e3_tx_ovh_regs.vh
/*
  Constants for the E3 G.832 transmit frame generator and error inserter:
  register offsets, field positions, reset values and frame geometry.
  Assumes inclusion by bare name from the design files and the bench top.
*/
`ifndef E3_TX_OVH_REGS_VH
`define E3_TX_OVH_REGS_VH

// ==========================================================
// Register offsets (byte addresses on APB)
`define OFS_CTRL 8'h00
`define OFS_MA 8'h04
`define OFS_NRGC 8'h08
`define OFS_ERR 8'h0c
`define OFS_STAT 8'h10

// ==========================================================
// Control register fields
`define CTRL_GEN_EN 0
`define CTRL_RDI_LO 1
`define CTRL_RDI_HI 2
`define CTRL_RDI_LOS 3
`define CTRL_RDI_LOF 4
`define CTRL_RDI_AIS 5
`define CTRL_REI_AUTO 6
`define CTRL_REI_VAL 7
`define CTRL_MF_GEN 8
`define CTRL_NR_LO 9
`define CTRL_NR_HI 10
`define CTRL_GC_HDLC 11
`define CTRL_W 12
`define CTRL_RST 12'h001

// RDI source and NR source codes
`define RDI_AUTO 2'h0
`define RDI_ONE 2'h1
`define RDI_ZERO 2'h2
`define NR_REG 2'h0
`define NR_FEAC 2'h1
`define NR_HDLC 2'h2

// ==========================================================
// Maintenance byte register: [2:0] payload, [5:3] direct, [9:6] timing
`define MA_W 10
`define MA_RST 10'h000
`define NRGC_RST 16'h0000

// ==========================================================
// Error insertion register fields
`define ERR_FA_EN 0
`define ERR_FA_WORD 1
`define ERR_FA_FOUR 2
`define ERR_BIP_EN 3
`define ERR_BIP_BYTE 4
`define ERR_BIP_CONT 5
`define ERR_REI_EN 6
`define ERR_REI_CONT 7
`define ERR_SRC_PIN 8
`define ERR_SW_REQ 9
`define ERR_W 9
`define ERR_RST 9'h000

// ==========================================================
// Frame geometry and overhead values
`define FRAME_BYTES 10'd531
`define POS_FA1 10'd0
`define POS_FA2 10'd1
`define POS_EM 10'd59
`define POS_TR 10'd118
`define POS_MA 10'd177
`define POS_NR 10'd236
`define POS_GC 10'd295
`define FA1_VAL 8'hf6
`define FA2_VAL 8'h28
`define FA1_ERR 8'h09
`define FA2_ERR 8'hd7
`define FA_ERR_BIT 8'h01
`define BIP_ERR_BIT 8'h01
`define FA_FOUR_CNT 3'h4
`define FA_ONE_CNT 3'h1

`endif

// File: design/pin_sync3.v
/*
  Three-stage synchroniser for an asynchronous pin with a rising-edge
  pulse. Assumes a single clock and an active-low asynchronous reset.
*/
`timescale 1ns/100ps

module pin_sync3 (
  input wire clock,
  input wire rst_n,
  input wire pin,
  output reg rise_r
);

  reg s1_r;
  reg s2_r;
  reg s3_r;
  reg level_r;

  // ==========================================================
  // Sync chain; level changes only when stages two and three agree
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      s1_r <= 1'b0;
      s2_r <= 1'b0;
      s3_r <= 1'b0;
      level_r <= 1'b0;
      rise_r <= 1'b0;
    end else begin
      s1_r <= pin;
      s2_r <= s1_r;
      s3_r <= s2_r;
      if (s2_r == s3_r) begin
        level_r <= s3_r;
      end
      rise_r <= (s2_r == s3_r) & s3_r & ~level_r;
    end
  end

endmodule // pin_sync3

// File: design/err_pending.v
/*
  One-deep pending flag for a single error insertion request.
  Assumes set and consume come from logic on the same clock.
*/
`timescale 1ns/100ps

module err_pending (
  input wire clock,
  input wire rst_n,
  input wire set,
  input wire consume,
  output reg pend_r
);

  // ==========================================================
  // Set wins over consume; repeated sets do not queue
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      pend_r <= 1'b0;
    end else begin
      pend_r <= set | (pend_r & ~consume);
    end
  end

endmodule // err_pending

// File: design/e3_tx_ovh_gen.v
/*
  G.832 E3 transmit frame generator and overhead error inserter with an
  APB register slave. Assumes a byte stream with a start-of-frame flag,
  alarm and parity inputs from the receive side on the same clock, and
  the fully processed downstream stream fed back for EM parity.
*/
`timescale 1ns/100ps
`include "e3_tx_ovh_regs.vh"

// Overview of operation
// - FA1/FA2 set to F6h and 28h
// - EM carries BIP-8 of previous final frame
// - TR byte from trail trace input
// - MA built from RDI, REI, type, multiframe
// - RDI auto, forced one or forced zero
// - LOS, LOF, AIS each enable auto RDI
// - REI from register or previous-frame parity
// - Payload type into MA bits 3-5
// - Last MA bits direct or generated
// - Generated phase counts, timing bits MSB first
// - NR from register, FEAC or HDLC
// - HDLC delivers one byte per frame
// - GC from register or HDLC
// - Generation off passes stream unchanged but for inserted errors
// - Framing bit error or 09h/D7h word
// - Framing errors single or four frames
// - EM one bit or all bits inverted
// - REI error forces MA bit two
// - Separate enables; EM and REI single or continuous modes
// - Request from register bit or pin
// - Generation, then errors, then downstream
module e3_tx_ovh_gen (
  input wire clock,
  input wire rst_n,
  input wire [7:0] paddr,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [31:0] pwdata,
  output reg [31:0] prdata_r,
  output reg pready_r,
  output reg pslverr_r,
  input wire [7:0] in_data,
  input wire in_valid,
  input wire in_sof,
  output reg [7:0] out_data_r,
  output reg out_valid_r,
  output reg out_sof_r,
  input wire [7:0] final_data,
  input wire final_valid,
  input wire final_sof,
  input wire [7:0] trail_trace_byte,
  input wire [7:0] feac_byte,
  input wire [7:0] hdlc_byte,
  output reg hdlc_read_r,
  input wire rx_los,
  input wire rx_lof,
  input wire rx_ais,
  input wire rx_parity_err,
  input wire manual_error_insert_input
);

  // ==========================================================
  // Registers and state
  reg [`CTRL_W-1:0] ctrl_r;
  reg [`MA_W-1:0] tx_maint_byte_register;
  reg [15:0] nrgc_r;
  reg [`ERR_W-1:0] err_r;
  reg sw_error_insert_request;
  reg [9:0] pos_r;
  reg [7:0] bip_acc_r;
  reg [7:0] em_r;
  reg [1:0] mf_phase_r;
  reg rei_acc_r;
  reg rei_prev_r;
  reg [7:0] hdlc_hold_r;
  reg [2:0] fa_cnt_r;

  wire pin_rise;
  wire fa_pend;
  wire bip_pend;
  wire rei_pend;

  // ==========================================================
  // APB decode
  wire apb_setup = psel & ~penable;
  wire apb_write = psel & penable & pready_r & pwrite;
  wire hit_ctrl = (paddr == `OFS_CTRL);
  wire hit_ma = (paddr == `OFS_MA);
  wire hit_nrgc = (paddr == `OFS_NRGC);
  wire hit_err = (paddr == `OFS_ERR);
  wire hit_stat = (paddr == `OFS_STAT);
  wire hit_any = hit_ctrl | hit_ma | hit_nrgc | hit_err | hit_stat;

  // Control fields
  wire gen_en = ctrl_r[`CTRL_GEN_EN];
  wire [1:0] rdi_mode = ctrl_r[`CTRL_RDI_HI:`CTRL_RDI_LO];
  wire [1:0] nr_src = ctrl_r[`CTRL_NR_HI:`CTRL_NR_LO];
  wire gc_hdlc = ctrl_r[`CTRL_GC_HDLC];
  wire [2:0] payload_type = tx_maint_byte_register[2:0];
  wire [2:0] mf_direct = tx_maint_byte_register[5:3];
  wire timing_source_bit0 = tx_maint_byte_register[6];
  wire timing_source_bit1 = tx_maint_byte_register[7];
  wire timing_source_bit2 = tx_maint_byte_register[8];
  wire timing_source_bit3 = tx_maint_byte_register[9];

  // ==========================================================
  // Frame position of the incoming byte
  wire [9:0] cur_pos = in_sof ? `POS_FA1 : pos_r;
  wire at_fa1 = in_valid & (cur_pos == `POS_FA1);
  wire at_fa2 = in_valid & (cur_pos == `POS_FA2);
  wire at_em = in_valid & (cur_pos == `POS_EM);
  wire at_tr = in_valid & (cur_pos == `POS_TR);
  wire at_ma = in_valid & (cur_pos == `POS_MA);
  wire at_nr = in_valid & (cur_pos == `POS_NR);
  wire at_gc = in_valid & (cur_pos == `POS_GC);
  wire frame_start = in_valid & in_sof;

  // ==========================================================
  // Request source and pending flags
  // register bit or pin
  wire err_req = err_r[`ERR_SRC_PIN] ? pin_rise : sw_error_insert_request;
  wire fa_en = err_r[`ERR_FA_EN];
  wire bip_en = err_r[`ERR_BIP_EN];
  wire rei_en = err_r[`ERR_REI_EN];
  wire bip_cont = err_r[`ERR_BIP_CONT];
  wire rei_cont = err_r[`ERR_REI_CONT];

  wire fa_load = at_fa1 & fa_en & fa_pend & (fa_cnt_r == 3'h0);
  wire fa_hit = fa_en & ((fa_cnt_r != 3'h0) | fa_load);
  wire bip_hit = bip_en & (bip_cont | bip_pend);
  wire rei_hit = rei_en & (rei_cont | rei_pend);

  // Pin request edge
  pin_sync3 u_pin_sync (
    .clock(clock),
    .rst_n(rst_n),
    .pin(manual_error_insert_input),
    .rise_r(pin_rise)
  );

  err_pending u_fa_pend (
    .clock(clock),
    .rst_n(rst_n),
    .set(err_req & fa_en),
    .consume(fa_load),
    .pend_r(fa_pend)
  );

  err_pending u_bip_pend (
    .clock(clock),
    .rst_n(rst_n),
    .set(err_req & bip_en & ~bip_cont),
    .consume(at_em & ~bip_cont),
    .pend_r(bip_pend)
  );

  err_pending u_rei_pend (
    .clock(clock),
    .rst_n(rst_n),
    .set(err_req & rei_en & ~rei_cont),
    .consume(at_ma & ~rei_cont),
    .pend_r(rei_pend)
  );

  // ==========================================================
  // MA byte assembly
  reg rdi_bit;
  reg rei_bit;
  reg ts_bit;
  reg [2:0] mf_bits;
  wire alarm_any = (rx_los & ctrl_r[`CTRL_RDI_LOS]) | (rx_lof & ctrl_r[`CTRL_RDI_LOF])
                 | (rx_ais & ctrl_r[`CTRL_RDI_AIS]);

  always @* begin
    case (rdi_mode)
      `RDI_AUTO: rdi_bit = alarm_any;
      `RDI_ONE: rdi_bit = 1'b1;
      `RDI_ZERO: rdi_bit = 1'b0;
      default: rdi_bit = 1'b0;
    endcase
    rei_bit = ctrl_r[`CTRL_REI_AUTO] ? rei_prev_r : ctrl_r[`CTRL_REI_VAL];
    case (mf_phase_r)
      2'h0: ts_bit = timing_source_bit3;
      2'h1: ts_bit = timing_source_bit2;
      2'h2: ts_bit = timing_source_bit1;
      2'h3: ts_bit = timing_source_bit0;
      default: ts_bit = 1'b0;
    endcase
    mf_bits = ctrl_r[`CTRL_MF_GEN] ? {mf_phase_r, ts_bit} : mf_direct;
  end

  wire [7:0] ma_byte = {rdi_bit, rei_bit, payload_type, mf_bits};

  // ==========================================================
  // Stage one: frame generation
  reg [7:0] gen_byte;
  reg [7:0] nr_byte;

  always @* begin
    case (nr_src)
      `NR_REG: nr_byte = nrgc_r[7:0];
      `NR_FEAC: nr_byte = feac_byte;
      `NR_HDLC: nr_byte = hdlc_byte;
      default: nr_byte = nrgc_r[7:0];
    endcase
    gen_byte = in_data;
    if (gen_en) begin
      if (at_fa1) begin
        gen_byte = `FA1_VAL;
      end else if (at_fa2) begin
        gen_byte = `FA2_VAL;
      end else if (at_em) begin
        gen_byte = em_r;
      end else if (at_tr) begin
        gen_byte = trail_trace_byte;
      end else if (at_ma) begin
        gen_byte = ma_byte;
      end else if (at_nr) begin
        gen_byte = nr_byte;
      end else if (at_gc) begin
        gen_byte = gc_hdlc ? hdlc_hold_r : nrgc_r[15:8];
      end
    end
  end

  // ==========================================================
  // Stage two: error insertion on the generated byte
  reg [7:0] err_byte;

  always @* begin
    err_byte = gen_byte;
    if (fa_hit & (at_fa1 | at_fa2)) begin
      if (err_r[`ERR_FA_WORD]) begin
        err_byte = at_fa1 ? `FA1_ERR : `FA2_ERR;
      end else if (at_fa1) begin
        err_byte = gen_byte ^ `FA_ERR_BIT;
      end
    end
    if (bip_hit & at_em) begin
      err_byte = gen_byte ^ (err_r[`ERR_BIP_BYTE] ? 8'hff : `BIP_ERR_BIT);
    end
    if (rei_hit & at_ma) begin
      err_byte = gen_byte | 8'h40;
    end
  end

  // ==========================================================
  // Output register and frame counters
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      out_data_r <= 8'h00;
      out_valid_r <= 1'b0;
      out_sof_r <= 1'b0;
      pos_r <= 10'h000;
      mf_phase_r <= 2'h0;
      fa_cnt_r <= 3'h0;
    end else begin
      out_data_r <= in_valid ? err_byte : out_data_r;
      out_valid_r <= in_valid;
      out_sof_r <= frame_start;
      if (in_valid) begin
        pos_r <= (cur_pos == `FRAME_BYTES - 10'd1) ? 10'h000 : cur_pos + 10'd1;
      end
      if (at_ma) begin
        mf_phase_r <= mf_phase_r + 2'h1;
      end
      if (fa_load) begin
        fa_cnt_r <= err_r[`ERR_FA_FOUR] ? `FA_FOUR_CNT : `FA_ONE_CNT;
      end else if (at_fa2 & (fa_cnt_r != 3'h0)) begin
        fa_cnt_r <= fa_cnt_r - 3'h1;
      end
    end
  end

  // ==========================================================
  // BIP-8 over the final stream and REI accumulation
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      bip_acc_r <= 8'h00;
      em_r <= 8'h00;
      rei_acc_r <= 1'b0;
      rei_prev_r <= 1'b0;
    end else begin
      if (final_valid & final_sof) begin
        em_r <= bip_acc_r;
        bip_acc_r <= final_data;
      end else if (final_valid) begin
        bip_acc_r <= bip_acc_r ^ final_data;
      end
      if (frame_start) begin
        rei_prev_r <= rei_acc_r | rx_parity_err;
        rei_acc_r <= 1'b0;
      end else begin
        rei_acc_r <= rei_acc_r | rx_parity_err;
      end
    end
  end

  // ==========================================================
  // HDLC byte taken once per frame
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      hdlc_read_r <= 1'b0;
      hdlc_hold_r <= 8'h00;
    end else begin
      hdlc_read_r <= at_nr & gen_en & (gc_hdlc | (nr_src == `NR_HDLC));
      if (at_nr) begin
        hdlc_hold_r <= hdlc_byte;
      end
    end
  end

  // ==========================================================
  // APB register writes
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_r <= `CTRL_RST;
      tx_maint_byte_register <= `MA_RST;
      nrgc_r <= `NRGC_RST;
      err_r <= `ERR_RST;
      sw_error_insert_request <= 1'b0;
    end else begin
      sw_error_insert_request <= apb_write & hit_err & pwdata[`ERR_SW_REQ];
      if (apb_write & hit_ctrl) begin
        ctrl_r <= pwdata[`CTRL_W-1:0];
      end
      if (apb_write & hit_ma) begin
        tx_maint_byte_register <= pwdata[`MA_W-1:0];
      end
      if (apb_write & hit_nrgc) begin
        nrgc_r <= pwdata[15:0];
      end
      if (apb_write & hit_err) begin
        err_r <= pwdata[`ERR_W-1:0];
      end
    end
  end

  // ==========================================================
  // APB read data and response, one wait-free access phase
  reg [31:0] rd_mux;

  always @* begin
    rd_mux = 32'h00000000;
    if (hit_ctrl) begin
      rd_mux = {20'h00000, ctrl_r};
    end else if (hit_ma) begin
      rd_mux = {22'h000000, tx_maint_byte_register};
    end else if (hit_nrgc) begin
      rd_mux = {16'h0000, nrgc_r};
    end else if (hit_err) begin
      rd_mux = {23'h000000, err_r};
    end else if (hit_stat) begin
      rd_mux = {18'h00000, rdi_bit, rei_pend, bip_pend, fa_pend, mf_phase_r, em_r};
    end
  end

  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      prdata_r <= 32'h00000000;
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
    end else begin
      pready_r <= apb_setup;
      pslverr_r <= apb_setup & ~hit_any;
      if (apb_setup) begin
        prdata_r <= pwrite ? 32'h00000000 : rd_mux;
      end
    end
  end

endmodule // e3_tx_ovh_gen

// File: bench/e3_tx_ovh_gen_assertions.sv
/*
  Port checker for the E3 transmit overhead block.
  Assumes one clock and the block's active-low async reset.
*/
`timescale 1ns/100ps
module e3_tx_ovh_chk (
  input wire clock,
  input wire rst_n,
  input wire [7:0] paddr,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [31:0] pwdata,
  input wire pready_r,
  input wire pslverr_r,
  input wire [7:0] in_data,
  input wire in_valid,
  input wire in_sof,
  input wire [7:0] out_data_r,
  input wire out_valid_r,
  input wire out_sof_r,
  input wire hdlc_read_r
);
  reg gen_r;
  reg fa_r;
  // ==========================================
  // Shadow of generation and framing enables
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      gen_r <= 1'h1;
      fa_r <= 1'h0;
    end else if (psel && penable && pready_r && pwrite) begin
      if (paddr == 8'h00) gen_r <= pwdata[0];
      if (paddr == 8'h0c) fa_r <= pwdata[0];
    end
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  property p_answer; psel && !penable |=> pready_r; endproperty
  a_answer: assert property (p_answer) else $error("no ready after setup");
  property p_pulse; pready_r |=> !pready_r; endproperty
  a_pulse: assert property (p_pulse) else $error("ready too long");
  property p_unmap; psel && penable && pready_r && paddr > 8'h10 |-> pslverr_r; endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped not refused");
  property p_errq; pslverr_r |-> pready_r && psel && penable; endproperty
  a_errq: assert property (p_errq) else $error("stray slave error");
  property p_sof; in_valid && in_sof |=> out_sof_r && out_valid_r; endproperty
  a_sof: assert property (p_sof) else $error("frame start lost");
  property p_fa;
    in_valid && in_sof && gen_r && !fa_r ##1 in_valid && gen_r && !fa_r
      |-> out_data_r == 8'hf6 ##1 out_data_r == 8'h28;
  endproperty
  a_fa: assert property (p_fa) else $error("alignment bytes wrong");
  property p_pass;
    in_valid && in_sof && !gen_r && !fa_r |=> out_data_r == $past(in_data);
  endproperty
  a_pass: assert property (p_pass) else $error("passthrough altered");
  property p_hdlc; hdlc_read_r |=> !hdlc_read_r [*8]; endproperty
  a_hdlc: assert property (p_hdlc) else $error("hdlc read repeated");
  c_err: cover property (pslverr_r);
  c_sof: cover property (out_sof_r && gen_r);
  c_hdlc: cover property (hdlc_read_r);
endmodule // e3_tx_ovh_chk
bind e3_tx_ovh_gen e3_tx_ovh_chk i_chk (
  .clock(clock), .rst_n(rst_n), .paddr(paddr), .psel(psel), .penable(penable),
  .pwrite(pwrite), .pwdata(pwdata), .pready_r(pready_r), .pslverr_r(pslverr_r),
  .in_data(in_data), .in_valid(in_valid), .in_sof(in_sof), .out_data_r(out_data_r),
  .out_valid_r(out_valid_r), .out_sof_r(out_sof_r), .hdlc_read_r(hdlc_read_r)
);

// File: bench/e3_stream_partner.sv
/*
  Upstream byte source and downstream loopback for the E3 block.
  Assumes the block's clock and reset; no back-pressure.
*/
`timescale 1ns/100ps
module e3_stream_partner (
  input wire clock,
  input wire rst_n,
  input wire [7:0] out_data_r,
  input wire out_valid_r,
  input wire out_sof_r,
  input wire hdlc_read_r,
  output reg [7:0] in_data,
  output reg in_valid,
  output reg in_sof,
  output reg [7:0] final_data,
  output reg final_valid,
  output reg final_sof,
  output reg [7:0] trail_trace_byte,
  output reg [7:0] hdlc_byte,
  output wire [7:0] feac_byte
);
  reg [9:0] pos_r;
  assign feac_byte = 8'h5a;
  // ==========================================
  // Frame source, loopback and byte suppliers
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      pos_r <= 10'h000;
      in_data <= 8'h00;
      in_valid <= 1'h0;
      in_sof <= 1'h0;
      final_data <= 8'h00;
      final_valid <= 1'h0;
      final_sof <= 1'h0;
      trail_trace_byte <= 8'ha0;
      hdlc_byte <= 8'h30;
    end else begin
      in_valid <= 1'h1;
      in_sof <= (pos_r == 10'h000);
      in_data <= pos_r[7:0];
      pos_r <= (pos_r == 10'd530) ? 10'h000 : pos_r + 10'h001;
      final_data <= out_data_r;
      final_valid <= out_valid_r;
      final_sof <= out_sof_r;
      if (hdlc_read_r) hdlc_byte <= hdlc_byte + 8'h11;
      if (pos_r == 10'h000) trail_trace_byte <= trail_trace_byte + 8'h01;
    end
  end
endmodule // e3_stream_partner

// File: bench/e3_g832_tx_overhead_error_gen_tb_top.sv
/*
  Self-checking bench for the E3 transmit overhead block.
  Assumes the design header is on the include path.
*/
`timescale 1ns/100ps
`include "e3_tx_ovh_regs.vh"
module e3_g832_tx_overhead_error_gen_tb_top;
  reg clock, rst_n, psel, penable, pwrite, rx_los, rx_lof, rx_ais, rx_parity_err, man_pin;
  reg [7:0] paddr;
  reg [31:0] pwdata;
  wire [31:0] prdata_r;
  wire pready_r, pslverr_r, out_valid_r, out_sof_r, hdlc_read_r, in_valid, in_sof;
  wire final_valid, final_sof;
  wire [7:0] out_data_r, in_data, final_data, trail_trace_byte, feac_byte, hdlc_byte;
  reg [7:0] ob [0:530];
  reg [7:0] cx, px, tt, hd;
  integer err_total = 0;
  integer checks_done = 0;
  integer cyc = 0;
  localparam [3:0] tsi = 4'ha;
  e3_tx_ovh_gen i_dut (.clock(clock), .rst_n(rst_n), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata_r(prdata_r),
    .pready_r(pready_r), .pslverr_r(pslverr_r), .in_data(in_data), .in_valid(in_valid),
    .in_sof(in_sof), .out_data_r(out_data_r), .out_valid_r(out_valid_r),
    .out_sof_r(out_sof_r), .final_data(final_data), .final_valid(final_valid),
    .final_sof(final_sof), .trail_trace_byte(trail_trace_byte), .feac_byte(feac_byte),
    .hdlc_byte(hdlc_byte), .hdlc_read_r(hdlc_read_r), .rx_los(rx_los), .rx_lof(rx_lof),
    .rx_ais(rx_ais), .rx_parity_err(rx_parity_err), .manual_error_insert_input(man_pin));
  e3_stream_partner i_partner (.clock(clock), .rst_n(rst_n), .out_data_r(out_data_r),
    .out_valid_r(out_valid_r), .out_sof_r(out_sof_r), .hdlc_read_r(hdlc_read_r),
    .in_data(in_data), .in_valid(in_valid), .in_sof(in_sof), .final_data(final_data),
    .final_valid(final_valid), .final_sof(final_sof), .trail_trace_byte(trail_trace_byte),
    .hdlc_byte(hdlc_byte), .feac_byte(feac_byte));
  // ==========================================
  // Clock and hang guard
  initial begin
    clock = 1'h0;
    forever #5 clock = ~clock;
  end
  always @(posedge clock) begin
    cyc = cyc + 1;
    if (cyc == 40000) begin
      err_total = err_total + 1;
      tally_and_finish;
    end
  end
  task tally_and_finish;
    begin
      $display("mismatches %0d checks %0d", err_total, checks_done);
      if (err_total == 0 && checks_done > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
    end
  endtask
  task chk(input string nm, input [31:0] e, input [31:0] g);
    begin
      checks_done = checks_done + 1;
      if (g !== e) begin
        err_total = err_total + 1;
        $display("BAD %s expected %h seen %h", nm, e, g);
      end
    end
  endtask
  // One APB transfer, waits for ready
  task apb(input [7:0] a, input w, input [31:0] d, output [31:0] q, output e);
    begin
      @(posedge clock);
      psel <= 1'h1;
      penable <= 1'h0;
      paddr <= a;
      pwrite <= w;
      pwdata <= d;
      @(posedge clock);
      penable <= 1'h1;
      @(posedge clock);
      while (pready_r !== 1'h1) @(posedge clock);
      q = prdata_r;
      e = pslverr_r;
      psel <= 1'h0;
      penable <= 1'h0;
    end
  endtask
  // Capture one output frame; cont means already at its start
  task grab(input cont);
    integer i;
    begin
      px = cx;
      cx = 8'h00;
      // Skip a frame start launched before the last write took hold
      if (!cont) begin
        repeat (2) @(posedge clock);
        @(negedge clock);
      end
      while (!(out_sof_r === 1'h1 && out_valid_r === 1'h1)) @(negedge clock);
      for (i = 0; i < 531; i = i + 1) begin
        ob[i] = out_data_r;
        cx = cx ^ out_data_r;
        if (i == 118) tt = trail_trace_byte;
        if (i == 236) hd = hdlc_byte;
        @(negedge clock);
      end
    end
  endtask
  // ==========================================
  // Scenarios
  task t_regs;
    reg [31:0] q;
    reg e;
    begin
      apb(`OFS_CTRL, 1'h0, 32'h0, q, e);
      chk("ctrl_reset", 32'h1, q);
      apb(8'h14, 1'h0, 32'h0, q, e);
      chk("unmapped_err", 1, e);
    end
  endtask
  task t_gen;
    reg [31:0] q;
    reg e;
    reg [1:0] p;
    begin
      apb(`OFS_MA, 1'h1, 32'h2b5, q, e);
      apb(`OFS_NRGC, 1'h1, 32'hc33c, q, e);
      apb(`OFS_CTRL, 1'h1, 32'h183, q, e);
      grab(0);
      p = ob[177][2:1] + 2'h1;
      grab(1);
      chk("fa", 16'hf628, {ob[0], ob[1]});
      chk("em", px, ob[59]);
      chk("tr", tt, ob[118]);
      chk("ma", {2'h3, 3'h5, p, tsi[2'h3 - p]}, ob[177]);
      chk("nr_gc", 16'h3cc3, {ob[236], ob[295]});
    end
  endtask
  task t_rows;
    reg [31:0] q;
    reg e;
    reg [11:0] c;
    integer k;
    begin
      for (k = 0; k < 4; k = k + 1) begin
        case (k)
          0: c = 12'h205;
          1: c = 12'hc09;
          2: c = 12'h011;
          default: c = 12'h061;
        endcase
        apb(`OFS_CTRL, 1'h1, {20'h0, c}, q, e);
        rx_los <= 1'h1;
        rx_ais <= (k == 3);
        rx_parity_err <= (k == 3);
        grab(0);
        grab(1);
        chk("ma", {k[0], k == 3, 3'h5, 3'h6}, ob[177]);
        chk("nr", (k == 0) ? 8'h5a : (k == 1) ? hd : 8'h3c, ob[236]);
        chk("gc", (k == 1) ? hd : 8'hc3, ob[295]);
      end
    end
  endtask
  task t_fa;
    reg [31:0] q;
    reg e;
    integer f;
    begin
      apb(`OFS_ERR, 1'h1, 32'h207, q, e);
      rx_ais <= 1'h0;
      rx_parity_err <= 1'h0;
      for (f = 0; f < 5; f = f + 1) begin
        grab(f != 0);
        chk("fa_word", (f < 4) ? 16'h09d7 : 16'hf628, {ob[0], ob[1]});
      end
      apb(`OFS_ERR, 1'h1, 32'h201, q, e);
      grab(0);
      chk("fa_bit", 1, $countones({ob[0], ob[1]} ^ 16'hf628));
      grab(1);
      chk("fa_once", 16'hf628, {ob[0], ob[1]});
    end
  endtask
  task t_bip;
    reg [31:0] q;
    reg e;
    begin
      apb(`OFS_ERR, 1'h1, 32'h38, q, e);
      grab(0);
      grab(1);
      chk("em_byte", px ^ 8'hff, ob[59]);
      apb(`OFS_ERR, 1'h1, 32'h28, q, e);
      grab(0);
      grab(1);
      chk("em_bit", 1, $countones(ob[59] ^ px));
      // Single request made after the EM byte of the first captured frame
      fork
        begin
          grab(0);
          grab(1);
        end
        begin
          @(posedge out_sof_r);
          repeat (100) @(posedge clock);
          apb(`OFS_ERR, 1'h1, 32'h218, q, e);
        end
      join
      chk("em_one", px ^ 8'hff, ob[59]);
      grab(1);
      chk("em_once", px, ob[59]);
    end
  endtask
  task t_rei;
    reg [31:0] q;
    reg e;
    begin
      apb(`OFS_CTRL, 1'h1, 32'h1, q, e);
      // Past this frame's MA byte before requesting
      @(posedge out_sof_r);
      repeat (200) @(posedge clock);
      apb(`OFS_ERR, 1'h1, 32'h240, q, e);
      apb(`OFS_ERR, 1'h1, 32'h240, q, e);
      grab(0);
      chk("rei_sw", 1, ob[177][6]);
      grab(1);
      chk("rei_once", 0, ob[177][6]);
      repeat (200) @(posedge clock);
      apb(`OFS_ERR, 1'h1, 32'h140, q, e);
      man_pin <= 1'h1;
      repeat (4) @(posedge clock);
      man_pin <= 1'h0;
      grab(0);
      chk("rei_pin", 1, ob[177][6]);
      apb(`OFS_ERR, 1'h1, 32'hc0, q, e);
      grab(0);
      grab(1);
      chk("rei_cont", 1, ob[177][6]);
    end
  endtask
  task t_off;
    reg [31:0] q;
    reg e;
    integer i, n;
    begin
      apb(`OFS_ERR, 1'h1, 32'h0, q, e);
      apb(`OFS_CTRL, 1'h1, 32'h0, q, e);
      grab(0);
      n = 0;
      for (i = 0; i < 531; i = i + 1) if (ob[i] !== i[7:0]) n = n + 1;
      chk("passthrough", 0, n);
    end
  endtask
  // Reset, then every scenario in turn
  initial begin
    rst_n = 1'h0;
    psel = 1'h0;
    penable = 1'h0;
    pwrite = 1'h0;
    paddr = 8'h00;
    pwdata = 32'h0;
    rx_los = 1'h0;
    rx_lof = 1'h0;
    rx_ais = 1'h0;
    rx_parity_err = 1'h0;
    man_pin = 1'h0;
    cx = 8'h00;
    repeat (10) @(posedge clock);
    rst_n <= 1'h1;
    t_regs;
    t_gen;
    t_rows;
    t_fa;
    t_bip;
    t_rei;
    t_off;
    tally_and_finish;
  end
endmodule // e3_g832_tx_overhead_error_gen_tb_top
